//--- include/kpd_regs.svh
// register offsets, field positions, reset values, codes and timing of the key scanner
// assumes a 20 MHz system clock and a 128 kHz oscillator rate
`ifndef KPD_REGS_SVH
`define KPD_REGS_SVH

`define KPD_OFS_KEYS      8'h00
`define KPD_OFS_CFG       8'h01
`define KPD_OFS_DEBOUNCE  8'h02
`define KPD_OFS_IRQ       8'h03
`define KPD_OFS_REPEAT    8'h05
`define KPD_OFS_SLEEP     8'h06
`define KPD_OFS_SIZE      8'h30

`define KPD_RST_KEYS      8'h3F
`define KPD_RST_CFG       8'h0B
`define KPD_RST_DEBOUNCE  8'hFF
`define KPD_RST_IRQ       8'h00
`define KPD_RST_REPEAT    8'h00
`define KPD_RST_SLEEP     8'h07
`define KPD_RST_SIZE      8'hFF

`define KPD_CFG_RUN       7
`define KPD_CFG_IRQCLR    5
`define KPD_CFG_RELEASE   3
`define KPD_CFG_AWAKE     1
`define KPD_RPT_EN        7

`define KPD_CODE_REPEAT   8'h7E
`define KPD_CODE_OVERFLOW 8'h7F
`define KPD_KEY_SPECIAL   5'h1F

`define KPD_SYS_HZ        20000000
`define KPD_OSC_HZ        128000
`define KPD_WAKE_US       2000
`define KPD_DB_STEP_US    2000
`define KPD_RPT_DLY_STEP  8
`define KPD_RPT_RATE_STEP 4
`define KPD_LVL_STEP      2

`endif

//--- include/kpd_pkg.sv
// types shared by the key scanner files
// assumes nothing beyond a SystemVerilog compiler
package kpd_pkg;
    typedef enum logic [1:0] {
        KPD_SLEEPING = 2'b00,
        KPD_WARMING  = 2'b01,
        KPD_RUNNING  = 2'b10
    } kpd_mode_type;
endpackage

//--- src/kpd_event_mem.sv
// event storage for the key queue, registered read port
// assumes writer and reader keep their own pointers
`timescale 1ns/1ps
`default_nettype none
module kpd_event_mem
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
)(
    // clock
    input  wire logic                     sys_clk,
    // write side
    input  wire logic                     wrEn,
    input  wire logic [$clog2(DEPTH)-1:0] wrAddr,
    input  wire logic [WIDTH-1:0]         wrData,
    // read side
    input  wire logic [$clog2(DEPTH)-1:0] rdAddr,
    output logic      [WIDTH-1:0]         rdData
);
    logic [WIDTH-1:0] store [DEPTH];

    // refused at elaboration: pointers wrap only on a power of two
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
        $error("depth must be a power of two");

    always_ff @(posedge sys_clk)
    begin
        if (wrEn)
            store[wrAddr] <= wrData;
    end

    // no reset: contents are undefined until written
    always_ff @(posedge sys_clk)
    begin
        rdData <= store[rdAddr];
    end
endmodule
`default_nettype wire

//--- src/kpd_key_filter.sv
// one key's press/release filter in oscillator ticks
// assumes tick is a one-cycle pulse and ack comes only while pend is high
`timescale 1ns/1ps
`default_nettype none
module kpd_key_filter
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    // timing
    input  wire logic        tick,
    input  wire logic        run,
    input  wire logic [11:0] pressTicks,
    input  wire logic [11:0] releaseTicks,
    // key
    input  wire logic        raw,
    input  wire logic        ack,
    output logic             state,
    output logic             pend
);
    logic [11:0] cnt_reg;
    logic [11:0] limit;

    assign limit = state ? releaseTicks : pressTicks;

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            cnt_reg <= 12'h000;
        else if (!run || raw == state || pend)
            cnt_reg <= 12'h000;
        else if (tick)
            cnt_reg <= cnt_reg + 12'h001;
    end

    // held key after wake shows up as a fresh press
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            state <= 1'b0;
        else if (!run && !pend)
            state <= 1'b0;
        else if (run && !pend && raw != state && tick && cnt_reg + 12'h001 >= limit)
            state <= raw;
    end

    // pending event waits for the queue; set beats ack
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            pend <= 1'b0;
        else if (run && !pend && raw != state && tick && cnt_reg + 12'h001 >= limit)
            pend <= 1'b1;
        else if (ack)
            pend <= 1'b0;
    end
endmodule
`default_nettype wire

//--- src/kpd_scan_ctrl.sv
// key matrix scanner: filters, event queue, repeat, interrupt, sleep
// assumes a byte register port from the serial slave and per-key closure senses
`timescale 1ns/1ps
`default_nettype none
`include "kpd_regs.svh"

// Overview of operation
// - key index equals column times eight plus row
// - bit7 more data, bit6 release, except 62/63
// - queue read clears interrupt in clear-on-read mode
// - config bit7 sets mode, mirrors autosleep/autowake
// - low nibble press, high release, 2-32ms
// - 64kHz tick times debounce, wake and autosleep; others debounce cycles
// - interrupt register zero keeps interrupt off
// - low five bits: interrupt after debounce cycles
// - upper three bits: interrupt at queue level
// - both interrupt kinds, first condition wins
// - held key queues repeat code after delay
// - repeat enable, delay 8-128, rate 4-32
// - one repeat code per interval, until event
// - release with keys held restarts repeat delay
// - autosleep after idle time, queue kept
// - wake by host write or autowake keypress
// - wake waits 2ms then debounces waking key
// - sixteen entries, overflow code read first
// - overflow timing depends on release detection
// - size nibbles pick rows and columns used
// - one read returns event and status, pops
// - reset to sleep, rows low, columns high
module kpd_scan_ctrl
    import kpd_pkg::*;
#(
    parameter int FIFO_DEPTH       = 16,
    parameter int SLEEP_STEP_TICKS = 8192
)(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    // register port
    input  wire logic [7:0]  regAddr,
    input  wire logic [7:0]  regWrData,
    input  wire logic        regWrEn,
    input  wire logic        regRdEn,
    output logic      [7:0]  regRdData,
    output logic             regRdValid,
    // key matrix
    input  wire logic [63:0] keyClosed,
    output logic      [7:0]  matrixRowOut,
    output logic      [7:0]  matrixRowOe,
    output logic      [7:0]  matrixColOut,
    output logic      [7:0]  matrixColOe,
    output logic             currentSrcEn,
    // interrupt
    output logic             keyIrq_b
);
    localparam int AW        = $clog2(FIFO_DEPTH);
    localparam int TickDiv   = `KPD_SYS_HZ / (`KPD_OSC_HZ / 2);
    localparam int TickHz    = `KPD_OSC_HZ / 2;
    localparam int WakeTicks = (`KPD_WAKE_US * TickHz + 999999) / 1000000;
    localparam int StepTicks = (`KPD_DB_STEP_US * TickHz + 999999) / 1000000;

    if (FIFO_DEPTH != 16)
        $error("queue depth must be 16");
    if (SLEEP_STEP_TICKS < 1)
        $error("sleep step must be positive");

    ////////////////////////////////////////////////////////////////////////////
    logic [7:0]   cfg_reg;
    logic [7:0]   db_reg;
    logic [7:0]   irq_reg;
    logic [7:0]   rpt_reg;
    logic [7:0]   sleep_reg;
    logic [7:0]   size_reg;
    kpd_mode_type mode_reg;
    logic [8:0]   div_reg;
    logic         tick;
    logic [7:0]   warm_reg;
    logic [31:0]  idle_reg;
    logic [11:0]  pressTicks;
    logic [11:0]  releaseTicks;
    logic [11:0]  dbt_reg;
    logic         dbCycle;
    logic [63:0]  arrayMask;
    logic [63:0]  keyState;
    logic [63:0]  keyPend;
    logic [63:0]  keyAck;
    logic         evFound;
    logic [5:0]   evIdx;
    logic         anyRaw;
    logic         anyHeld;
    logic         run;
    logic         wrCfg;
    logic         rdKeys;
    logic         keyPush;
    logic         rptPush;
    logic         push;
    logic [7:0]   pushByte;
    logic         isRelease;
    logic [AW:0]  cnt_reg;
    logic [AW-1:0] wrPtr_reg;
    logic [AW-1:0] rdPtr_reg;
    logic         pushPrev_reg;
    logic         full;
    logic         readable;
    logic         doWrite;
    logic         pop;
    logic [7:0]   memQ;
    logic         ovf_reg;
    logic [1:0]   drop_reg;
    logic [8:0]   rpt_cnt_reg;
    logic         rptPhase_reg;
    logic [8:0]   rptTarget;
    logic         rptFire;
    logic [4:0]   tim_cnt_reg;
    logic         timRun_reg;
    logic         timeHit;
    logic         lvlHit;
    logic         int_reg;

    assign run    = (mode_reg == KPD_RUNNING);
    assign wrCfg  = regWrEn && regAddr == `KPD_OFS_CFG;
    assign rdKeys = regRdEn && regAddr == `KPD_OFS_KEYS;

    ////////////////////////////////////////////////////////////////////////////
    // 64kHz tick from the system clock
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            div_reg <= 9'h000;
        else if (tick)
            div_reg <= 9'h000;
        else
            div_reg <= div_reg + 9'h001;
    end
    assign tick = (div_reg == 9'(TickDiv - 1));

    // nibble n gives (n+1) steps of 2ms
    assign pressTicks   = 12'((32'(db_reg[3:0]) + 32'h1) * StepTicks);
    assign releaseTicks = 12'((32'(db_reg[7:4]) + 32'h1) * StepTicks);

    // debounce cycle paces repeat and timed interrupt
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            dbt_reg <= 12'h000;
        else if (dbCycle || !run)
            dbt_reg <= 12'h000;
        else if (tick)
            dbt_reg <= dbt_reg + 12'h001;
    end
    assign dbCycle = run && tick && (dbt_reg + 12'h001 >= pressTicks);

    ////////////////////////////////////////////////////////////////////////////
    // key k sits at row k%8, column k/8
    for (genvar k = 0; k < 64; k++)
    begin : g_key
        assign arrayMask[k] = (size_reg[7:4] > 4'(k % 8)) && (size_reg[3:0] > 4'(k / 8));
        kpd_key_filter u_filter (
            .sys_clk      (sys_clk),
            .rst_b        (rst_b),
            .tick         (tick),
            .run          (run),
            .pressTicks   (pressTicks),
            .releaseTicks (releaseTicks),
            .raw          (keyClosed[k] && arrayMask[k]),
            .ack          (keyAck[k]),
            .state        (keyState[k]),
            .pend         (keyPend[k])
        );
    end

    assign anyRaw  = |(keyClosed & arrayMask);
    assign anyHeld = |keyState;

    // lowest pending key goes first; others wait in their filters
    always_comb
    begin
        evFound = 1'b0;
        evIdx   = 6'h00;
        for (int k = 63; k >= 0; k--)
        begin
            if (keyPend[k])
            begin
                evFound = 1'b1;
                evIdx   = 6'(k);
            end
        end
    end
    assign keyAck    = evFound ? (64'h1 << evIdx) : 64'h0;
    assign isRelease = !keyState[evIdx];

    assign keyPush  = evFound && (!isRelease || cfg_reg[`KPD_CFG_RELEASE]);
    // repeat only when no real event this cycle
    assign rptPush  = rptFire && !evFound;
    assign push     = keyPush || rptPush;
    assign pushByte = keyPush ? {1'b0, isRelease, evIdx} : `KPD_CODE_REPEAT;

    ////////////////////////////////////////////////////////////////////////////
    // mode state drives config bit7
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            mode_reg <= KPD_SLEEPING;
        else
        begin
            case (mode_reg)
                KPD_SLEEPING:
                    if ((wrCfg && regWrData[`KPD_CFG_RUN]) || (cfg_reg[`KPD_CFG_AWAKE] && anyRaw))
                        mode_reg <= KPD_WARMING;
                KPD_WARMING:
                    if (wrCfg && !regWrData[`KPD_CFG_RUN])
                        mode_reg <= KPD_SLEEPING;
                    else if (tick && warm_reg + 8'h01 >= 8'(WakeTicks))
                        mode_reg <= KPD_RUNNING;
                KPD_RUNNING:
                    if (wrCfg && !regWrData[`KPD_CFG_RUN])
                        mode_reg <= KPD_SLEEPING;
                    else if (sleep_reg != 8'h00
                             && idle_reg >= 32'(sleep_reg) * 32'(SLEEP_STEP_TICKS))
                        mode_reg <= KPD_SLEEPING;
                default:
                    mode_reg <= KPD_SLEEPING;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            warm_reg <= 8'h00;
        else if (mode_reg != KPD_WARMING)
            warm_reg <= 8'h00;
        else if (tick)
            warm_reg <= warm_reg + 8'h01;
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            idle_reg <= 32'h0;
        else if (!run || anyRaw || anyHeld)
            idle_reg <= 32'h0;
        else if (tick && idle_reg != 32'hFFFF_FFFF)
            idle_reg <= idle_reg + 32'h1;
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cfg_reg   <= `KPD_RST_CFG;
            db_reg    <= `KPD_RST_DEBOUNCE;
            irq_reg   <= `KPD_RST_IRQ;
            rpt_reg   <= `KPD_RST_REPEAT;
            sleep_reg <= `KPD_RST_SLEEP;
            size_reg  <= `KPD_RST_SIZE;
        end
        else if (regWrEn)
        begin
            case (regAddr)
                `KPD_OFS_CFG:      cfg_reg   <= {1'b0, regWrData[6:0]};
                `KPD_OFS_DEBOUNCE: db_reg    <= regWrData;
                `KPD_OFS_IRQ:      irq_reg   <= regWrData;
                `KPD_OFS_REPEAT:   rpt_reg   <= regWrData;
                `KPD_OFS_SLEEP:    sleep_reg <= regWrData;
                `KPD_OFS_SIZE:     size_reg  <= regWrData;
                default:           cfg_reg   <= cfg_reg;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sixteen-entry queue, extra events dropped
    assign full     = (cnt_reg == (AW + 1)'(FIFO_DEPTH));
    assign doWrite  = push && !full;
    // entry pushed last cycle is not yet on the read port
    assign readable = pushPrev_reg ? (cnt_reg > (AW + 1)'(1)) : (cnt_reg != '0);
    // empty or overflow read pops nothing
    assign pop      = rdKeys && !ovf_reg && readable;

    kpd_event_mem #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_mem (
        .sys_clk (sys_clk),
        .wrEn    (doWrite),
        .wrAddr  (wrPtr_reg),
        .wrData  (pushByte),
        .rdAddr  (rdPtr_reg),
        .rdData  (memQ)
    );

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt_reg      <= '0;
            wrPtr_reg    <= '0;
            rdPtr_reg    <= '0;
            pushPrev_reg <= 1'b0;
        end
        else
        begin
            pushPrev_reg <= doWrite;
            if (doWrite)
                wrPtr_reg <= wrPtr_reg + AW'(1);
            if (pop)
                rdPtr_reg <= rdPtr_reg + AW'(1);
            if (doWrite && !pop)
                cnt_reg <= cnt_reg + (AW + 1)'(1);
            else if (pop && !doWrite)
                cnt_reg <= cnt_reg - (AW + 1)'(1);
        end
    end

    // early flag without release detection, 18th release clears
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ovf_reg  <= 1'b0;
            drop_reg <= 2'b00;
        end
        else
        begin
            if (!full)
                drop_reg <= 2'b00;
            else if (push && drop_reg != 2'b11)
                drop_reg <= drop_reg + 2'b01;
            if (!cfg_reg[`KPD_CFG_RELEASE] && doWrite && cnt_reg == (AW + 1)'(FIFO_DEPTH - 1))
                ovf_reg <= 1'b1;
            else if (cfg_reg[`KPD_CFG_RELEASE] && full && push && drop_reg == 2'b00)
                ovf_reg <= 1'b1;
            else if (full && keyPush && isRelease && drop_reg == 2'b01)
                ovf_reg <= 1'b0;
            else if (rdKeys)
                ovf_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // delay (n+1)*8, rate (m+1)*4 debounce cycles
    assign rptTarget = rptPhase_reg
        ? 9'((32'(rpt_reg[6:4]) + 32'h1) * `KPD_RPT_RATE_STEP)
        : 9'((32'(rpt_reg[3:0]) + 32'h1) * `KPD_RPT_DLY_STEP);
    // held key queues repeat code only
    assign rptFire = rpt_reg[`KPD_RPT_EN] && anyHeld && dbCycle
                     && (rpt_cnt_reg + 9'h001 >= rptTarget);

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rpt_cnt_reg  <= 9'h000;
            rptPhase_reg <= 1'b0;
        end
        // any real event restarts initial delay
        else if (evFound || !anyHeld)
        begin
            rpt_cnt_reg  <= 9'h000;
            rptPhase_reg <= 1'b0;
        end
        else if (rptPush)
        begin
            rpt_cnt_reg  <= 9'h000;
            rptPhase_reg <= 1'b1;
        end
        else if (dbCycle && rpt_cnt_reg != 9'h1FF)
            rpt_cnt_reg <= rpt_cnt_reg + 9'h001;
    end

    ////////////////////////////////////////////////////////////////////////////
    // timed interrupt after n debounce cycles
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tim_cnt_reg <= 5'h00;
            timRun_reg  <= 1'b0;
        end
        else if (doWrite)
        begin
            tim_cnt_reg <= 5'h00;
            timRun_reg  <= 1'b1;
        end
        else if (timeHit)
            timRun_reg <= 1'b0;
        else if (dbCycle && timRun_reg)
            tim_cnt_reg <= tim_cnt_reg + 5'h01;
    end
    assign timeHit = timRun_reg && dbCycle && (tim_cnt_reg + 5'h01 >= irq_reg[4:0])
                     && irq_reg[4:0] != 5'h00;
    assign lvlHit = irq_reg[7:5] != 3'h0
                    && cnt_reg >= (AW + 1)'(32'(irq_reg[7:5]) * `KPD_LVL_STEP);

    // either condition sets; set beats clear
    // clear on queue read when bit5 is 0
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            int_reg <= 1'b0;
        else if (timeHit || lvlHit)
            int_reg <= 1'b1;
        else if (!cfg_reg[`KPD_CFG_IRQCLR] && rdKeys)
            int_reg <= 1'b0;
        else if (cfg_reg[`KPD_CFG_IRQCLR] && cnt_reg == '0 && !ovf_reg)
            int_reg <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // one read gives event plus status
    // bit7 set while more data remains
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            regRdData  <= 8'h00;
            regRdValid <= 1'b0;
        end
        else
        begin
            regRdValid <= regRdEn;
            if (regRdEn)
            begin
                case (regAddr)
                    `KPD_OFS_KEYS:
                        if (ovf_reg)
                            regRdData <= `KPD_CODE_OVERFLOW;
                        else if (!readable)
                            regRdData <= `KPD_RST_KEYS;
                        // keys 62/63 carry no more-data bit
                        else if (memQ[5:1] == `KPD_KEY_SPECIAL)
                            regRdData <= {1'b0, memQ[6:0]};
                        else
                            regRdData <= {cnt_reg > (AW + 1)'(1), memQ[6:0]};
                    `KPD_OFS_CFG:      regRdData <= {mode_reg != KPD_SLEEPING, cfg_reg[6:0]};
                    `KPD_OFS_DEBOUNCE: regRdData <= db_reg;
                    `KPD_OFS_IRQ:      regRdData <= irq_reg;
                    `KPD_OFS_REPEAT:   regRdData <= rpt_reg;
                    `KPD_OFS_SLEEP:    regRdData <= sleep_reg;
                    `KPD_OFS_SIZE:     regRdData <= size_reg;
                    default:           regRdData <= 8'h00;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sleep drives rows low, columns high
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            matrixRowOut <= 8'h00;
            matrixRowOe  <= 8'h00;
            matrixColOut <= 8'hFF;
            matrixColOe  <= 8'h00;
            currentSrcEn <= 1'b0;
            keyIrq_b     <= 1'b1;
        end
        else
        begin
            for (int i = 0; i < 8; i++)
            begin
                matrixRowOe[i] <= !run && size_reg[7:4] > 4'(i);
                matrixColOe[i] <= !run && size_reg[3:0] > 4'(i);
            end
            matrixRowOut <= 8'h00;
            matrixColOut <= 8'hFF;
            currentSrcEn <= (mode_reg != KPD_SLEEPING);
            // zero setting keeps the pin idle
            keyIrq_b     <= !(int_reg && irq_reg != 8'h00);
        end
    end
endmodule
`default_nettype wire

//--- verif/kpd_scan_ctrl_props.sv
// port assertions for the key scanner
// assumes it is bound onto kpd_scan_ctrl
`timescale 1ns/1ps
`default_nettype none
module kpd_scan_props
(
    // watched ports
    input wire logic       sys_clk,
    input wire logic       rst_b,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic       regWrEn,
    input wire logic       regRdEn,
    input wire logic [7:0] regRdData,
    input wire logic       regRdValid,
    input wire logic [7:0] matrixRowOut,
    input wire logic [7:0] matrixColOut,
    input wire logic       currentSrcEn,
    input wire logic       keyIrq_b
);
    logic irqOff_reg;
    logic clrEmpty_reg;
    logic qRd_reg;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////
    // shadows of written settings and of queue reads
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            irqOff_reg   <= 1'b1;
            clrEmpty_reg <= 1'b0;
            qRd_reg      <= 1'b0;
        end
        else
        begin
            qRd_reg <= regRdEn && regAddr == 8'h00;
            if (regWrEn && regAddr == 8'h03)
                irqOff_reg <= regWrData == 8'h00;
            if (regWrEn && regAddr == 8'h01)
                clrEmpty_reg <= regWrData[5];
        end
    end
    ////////////////////////////////////////
    property p_sleepPins; !currentSrcEn |-> matrixRowOut == 8'h00 && matrixColOut == 8'hFF;
    endproperty
    a_sleepPins: assert property (p_sleepPins) else $error("sleep pins");
    property p_irqOff; irqOff_reg && $past(irqOff_reg) |-> keyIrq_b; endproperty
    a_irqOff: assert property (p_irqOff) else $error("irq while off");
    property p_rdAnswer; regRdEn |=> regRdValid; endproperty
    a_rdAnswer: assert property (p_rdAnswer) else $error("no read answer");
    property p_noSpurious; regRdValid |-> $past(regRdEn); endproperty
    a_noSpurious: assert property (p_noSpurious) else $error("stray valid");
    property p_rdHold; !$past(regRdEn) |-> $stable(regRdData); endproperty
    a_rdHold: assert property (p_rdHold) else $error("read data moved");
    property p_special; qRd_reg && regRdData[5:1] == 5'h1F |-> !regRdData[7]; endproperty
    a_special: assert property (p_special) else $error("more flag on 62/63");
    // later sets may win, so only an empty answer is tied to the clear
    property p_irqClear; qRd_reg && !clrEmpty_reg && regRdData == 8'h3F |-> ##[1:2] keyIrq_b;
    endproperty
    a_irqClear: assert property (p_irqClear) else $error("irq kept");
    property p_sleepWrite; regWrEn && regAddr == 8'h01 && !regWrData[7] |-> ##[1:3] !currentSrcEn;
    endproperty
    a_sleepWrite: assert property (p_sleepWrite) else $error("no sleep");
endmodule
bind kpd_scan_ctrl kpd_scan_props u_kpd_scan_props
(
    .sys_clk(sys_clk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid),
    .matrixRowOut(matrixRowOut), .matrixColOut(matrixColOut),
    .currentSrcEn(currentSrcEn), .keyIrq_b(keyIrq_b)
);
`default_nettype wire

//--- verif/kpd_host_model.sv
// host side of the register port
// assumes calls come from the bench after reset
`timescale 1ns/1ps
`default_nettype none
module kpd_host_model
(
    // clock
    input wire logic   sys_clk,
    // register requests
    output logic [7:0] regAddr,
    output logic [7:0] regWrData,
    output logic       regWrEn,
    output logic       regRdEn
);
    initial {regAddr, regWrData, regWrEn, regRdEn} = 18'h0;
    // one-cycle register write strobe, then an idle bus with inverted values
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk) #1 {regAddr, regWrData, regWrEn} = {a, d, 1'b1};
        @(posedge sys_clk) #1 {regAddr, regWrData, regWrEn} = {~a, ~d, 1'b0};
    endtask
    // trailing idle cycle keeps queue reads three cycles apart
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk) #1 {regAddr, regRdEn} = {a, 1'b1};
        @(posedge sys_clk) #1 {regAddr, regRdEn} = {~a, 1'b0};
        @(posedge sys_clk);
    endtask
endmodule
`default_nettype wire

//--- verif/kpd_scan_ctrl_tb.sv
// self-checking bench for the key scanner
// assumes the host model and the bound port checker
`timescale 1ns/1ps
`default_nettype none
module kpd_scan_ctrl_tb;
    logic        sys_clk;
    logic        rst_b;
    logic [63:0] keyClosed;
    logic [7:0]  regAddr, regWrData, regRdData, rowOe, colOe;
    logic        regWrEn, regRdEn, regRdValid, currentSrcEn, keyIrq_b;
    logic [7:0]  expQ[$];
    logic [7:0]  ofs[7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h06, 8'h30};
    logic [7:0]  rstv[7] = '{8'h3F, 8'h0B, 8'hFF, 8'h00, 8'h00, 8'h07, 8'hFF};
    int          errTotal = 0;
    int          checked = 0;
    int          n;
    integer      seed = 32'h73E2B659;
    logic [31:0] rnd;
    ////////////////////////////////////////
    kpd_scan_ctrl #(.FIFO_DEPTH(16), .SLEEP_STEP_TICKS(4)) u_kpd_scan_ctrl
    (
        .sys_clk(sys_clk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
        .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid),
        .keyClosed(keyClosed), .matrixRowOut(), .matrixRowOe(rowOe), .matrixColOut(),
        .matrixColOe(colOe), .currentSrcEn(currentSrcEn), .keyIrq_b(keyIrq_b)
    );
    kpd_host_model u_kpd_host_model
    (
        .sys_clk(sys_clk), .regAddr(regAddr), .regWrData(regWrData),
        .regWrEn(regWrEn), .regRdEn(regRdEn)
    );
    ////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
        checked++;
        if (seen !== want)
        begin
            errTotal++;
            $display("wrong value %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [7:0] want);
        expQ.push_back(want);
        u_kpd_host_model.rd(a);
    endtask
    task automatic reportAndStop();
        $display("checks %0d mismatches %0d", checked, errTotal);
        if (errTotal == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    ////////////////////////////////////////
    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    // read answers settle by the falling edge
    always @(negedge sys_clk)
        if (regRdValid === 1'b1)
            check("read", regRdData, expQ.pop_front());
    // wake plus one press is about 80000 cycles
    initial
    begin
        repeat (100000) @(posedge sys_clk);
        errTotal++;
        reportAndStop();
    end
    initial
    begin
        rst_b = 1'b0;
        keyClosed = 64'h0;
        repeat (3) @(posedge sys_clk);
        #1 rst_b = 1'b1;
        for (int i = 0; i < 7; i++)
            rdChk(ofs[i], rstv[i]);
        rdChk(8'h04, 8'h00);
        rnd = $random(seed);
        u_kpd_host_model.wr(8'h05, {1'b0, rnd[6:0]});
        rdChk(8'h05, {1'b0, rnd[6:0]});
        $display("register test done");
        u_kpd_host_model.wr(8'h02, 8'h00);
        u_kpd_host_model.wr(8'h06, 8'h00);
        u_kpd_host_model.wr(8'h03, 8'h20);
        u_kpd_host_model.wr(8'h01, 8'h8B);
        keyClosed = 64'hC000_0000_0000_0200;
        n = 0;
        while (keyIrq_b !== 1'b0 && n < 90000)
        begin
            @(posedge sys_clk) #1 n++;
        end
        check("irq", {7'h00, keyIrq_b}, 8'h00);
        // 2ms warm-up plus 2ms press filter
        check("wait", {7'h00, n >= 79500 && n <= 80500}, 8'h01);
        repeat (3) @(posedge sys_clk);
        rdChk(8'h00, 8'h89);
        rdChk(8'h00, 8'h3E);
        rdChk(8'h00, 8'h3F);
        rdChk(8'h00, 8'h3F);
        check("irq", {7'h00, keyIrq_b}, 8'h01);
        keyClosed = 64'h0;
        u_kpd_host_model.wr(8'h01, 8'h0B);
        repeat (2) @(posedge sys_clk);
        check("source", {7'h00, currentSrcEn}, 8'h00);
        check("row drive", rowOe, 8'hFF);
        check("column drive", colOe, 8'hFF);
        rdChk(8'h01, 8'h0B);
        $display("key test done");
        reportAndStop();
    end
endmodule
`default_nettype wire
